/* hw/display_control_cmd_regs.sv */
// command-addressed control and status registers of the display controller
`timescale 1ns/1ps
`include "display_control_regs.svh"

module display_control_cmd_regs (
  input  wire logic                             clk,
  input  wire logic                             rst_n,
  input  wire logic                             req_valid,
  input  wire display_control_pkg::cmd_req_type req,
  output logic                                  rsp_valid,
  output display_control_pkg::cmd_rsp_type      rsp,
  input  wire logic                             test_pattern_gen_on,
  input  wire logic                             line_pattern,
  input  wire logic                             hi_res_source,
  input  wire logic [15:0]                      array_width_in,
  input  wire logic [15:0]                      array_height_in,
  input  wire logic [2:0]                       power_phase_in,
  output logic [4:0]                            border_width_out,
  output logic                                  border_use_fg,
  output logic [15:0]                           pattern_width,
  output logic [15:0]                           pattern_height,
  output display_control_pkg::gamma_shift_type  gamma_shift,
  output logic [15:0]                           line_pixel_total,
  output logic [31:0]                           pixel_clock_hz,
  output display_control_pkg::source_desc_type  source_desc,
  output logic                                  prog_mode_active,
  output logic                                  partial_shutdown,
  output logic                                  system_restart,
  output logic [1:0]                            spread_level,
  output logic                                  restart_cpu_a,
  output logic                                  restart_cpu_b,
  output logic                                  usb_clock_on,
  output logic [4:0]                            vertical_smoothing,
  output logic [4:0]                            horizontal_smoothing,
  output logic                                  vert_filter_on,
  output logic                                  horiz_filter_on,
  output logic                                  scaler_skip,
  output logic [1:0]                            fan_select,
  output logic [2:0]                            fan_switch_rate,
  output logic                                  input_logic_reset
);

  function automatic logic is_write(input logic [7:0] code);
    return req_valid && req.write && (req.cmd == code);
  endfunction : is_write

  function automatic logic in_range(input logic [15:0] v,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi,
                                    input logic [15:0] lim);
    return (v >= lo) && (v <= hi) && (v <= lim);
  endfunction : in_range

  logic [4:0]   border_q;
  logic [15:0]  pat_w_q;
  logic [15:0]  pat_h_q;
  logic [23:0]  gamma_q;
  logic [47:0]  pixclk_q;
  logic [127:0] src_desc_q;
  logic [1:0]   spread_q;
  logic [15:0]  arr_w_q;
  logic [15:0]  arr_h_q;
  logic [2:0]   phase_q;
  logic [2:0]   tally_q;
  logic         usb_q;
  logic [4:0]   vsmooth_q;
  logic [4:0]   hsmooth_q;
  logic         skip_q;
  logic [1:0]   fan_sel_q;
  logic [2:0]   fan_rate_q;
  logic         shutdown_q;
  logic         sys_restart_q;
  logic         cpu_a_q;
  logic         cpu_b_q;
  logic         in_reset_q;
  logic         rsp_valid_q;
  display_control_pkg::cmd_rsp_type rsp_q;
  display_control_pkg::prog_mode_type mode_q;

  logic [127:0] wd;
  logic [127:0] rdata_d;
  logic         unknown_d;
  logic         restart_any;
  display_control_pkg::restart_target_type target;

  assign wd     = req.wdata;
  assign target = display_control_pkg::restart_target_type'(wd[1:0]);

  // out-of-range widths are dropped rather than clamped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      border_q <= 5'h00;
    end else if (is_write(`CMD_BORDER_WIDTH) && wd[4:0] <= `BORDER_MAX) begin
      border_q <= wd[4:0];
    end
  end

  // border only takes effect once the generator runs
  assign border_width_out = (test_pattern_gen_on && !hi_res_source) ? border_q
                                                            : 5'h00;
  assign border_use_fg    = line_pattern;

  // whole write refused if either axis is out of range
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pat_w_q <= 16'h0000;
      pat_h_q <= 16'h0000;
    end else if (is_write(`CMD_PATTERN_SIZE) &&
                 in_range(wd[31:16], `PATTERN_WIDTH_MIN,
                          `PATTERN_WIDTH_MAX, arr_w_q) &&
                 in_range(wd[15:0], `PATTERN_HEIGHT_MIN,
                          `PATTERN_HEIGHT_MAX, arr_h_q)) begin
      pat_w_q <= wd[31:16];
      pat_h_q <= wd[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gamma_q  <= 24'h000000;
      pixclk_q <= 48'h000000000000;
    end else begin
      if (is_write(`CMD_GAMMA_SHIFT)) begin
        gamma_q <= wd[23:0];
      end
      if (is_write(`CMD_PIXEL_CLOCK_INFO)) begin
        pixclk_q <= wd[47:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src_desc_q <= 128'h0;
    end else if (is_write(`CMD_SOURCE_DESCRIPTOR)) begin
      src_desc_q <= wd & `SRC_DESC_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q        <= display_control_pkg::MODE_NORMAL;
      shutdown_q    <= 1'b0;
      sys_restart_q <= 1'b0;
    end else begin
      shutdown_q    <= 1'b0;
      sys_restart_q <= 1'b0;
      case (mode_q)
        display_control_pkg::MODE_NORMAL: begin
          if (is_write(`CMD_PROGRAMMING_MODE) && wd[0]) begin
            mode_q     <= display_control_pkg::MODE_SHUTDOWN;
            shutdown_q <= 1'b1;
          end
        end
        display_control_pkg::MODE_SHUTDOWN: begin
          mode_q <= display_control_pkg::MODE_PROGRAM;
        end
        display_control_pkg::MODE_PROGRAM: begin
          if (is_write(`CMD_PROGRAMMING_MODE) && wd[0]) begin
            mode_q        <= display_control_pkg::MODE_NORMAL;
            sys_restart_q <= 1'b1;
          end
        end
        default: begin
          mode_q <= display_control_pkg::MODE_NORMAL;
        end
      endcase
    end
  end

  assign prog_mode_active = (mode_q == display_control_pkg::MODE_PROGRAM);
  assign partial_shutdown = shutdown_q;
  assign system_restart   = sys_restart_q;

  // code 3 names no target and is ignored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpu_a_q <= 1'b0;
      cpu_b_q <= 1'b0;
    end else begin
      cpu_a_q <= is_write(`CMD_SOFT_RESTART) &&
                 (target == display_control_pkg::RESTART_CPU_A ||
                  target == display_control_pkg::RESTART_CPU_AB);
      cpu_b_q <= is_write(`CMD_SOFT_RESTART) &&
                 (target == display_control_pkg::RESTART_CPU_B ||
                  target == display_control_pkg::RESTART_CPU_AB);
    end
  end

  assign restart_cpu_a = cpu_a_q;
  assign restart_cpu_b = cpu_b_q;
  assign restart_any   = cpu_a_q || cpu_b_q || sys_restart_q;

  // only power-up reset clears the tally
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tally_q <= 3'h0;
    end else if (restart_any && tally_q != `RESTART_TALLY_MAX) begin
      tally_q <= tally_q + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arr_w_q <= 16'h0000;
      arr_h_q <= 16'h0000;
      phase_q <= 3'h0;
    end else begin
      arr_w_q <= array_width_in;
      arr_h_q <= array_height_in;
      phase_q <= power_phase_in;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      spread_q  <= 2'h0;
      usb_q     <= 1'b0;
      vsmooth_q <= 5'h00;
      hsmooth_q <= 5'h00;
      skip_q    <= 1'b0;
    end else begin
      if (is_write(`CMD_ARRAY_CLOCK_SPREAD)) begin
        spread_q <= wd[1:0];
      end
      if (is_write(`CMD_USB_CLOCK_GATE)) begin
        usb_q <= wd[0];
      end
      if (is_write(`CMD_VERT_SMOOTHING)) begin
        vsmooth_q <= wd[4:0];
      end
      if (is_write(`CMD_HORIZ_SMOOTHING)) begin
        hsmooth_q <= wd[4:0];
      end
      if (is_write(`CMD_SCALER_SKIP)) begin
        skip_q <= wd[0];
      end
    end
  end

  assign spread_level         = spread_q;
  assign usb_clock_on         = usb_q;
  assign vertical_smoothing   = vsmooth_q;
  assign horizontal_smoothing = hsmooth_q;
  // the mid value turns the filter off
  assign vert_filter_on  = (vsmooth_q != `SMOOTHING_FILTER_OFF);
  assign horiz_filter_on = (hsmooth_q != `SMOOTHING_FILTER_OFF);
  assign scaler_skip     = skip_q;

  // select of zero is not a fan, so the old one stays
  // rate lands on the fan named in the same write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fan_sel_q  <= `FAN_SELECT_RESET;
      fan_rate_q <= 3'h0;
    end else if (is_write(`CMD_FAN_DRIVE_SETUP) &&
                 wd[`FAN_SELECT_LSB+:2] != 2'h0) begin
      fan_sel_q <= wd[`FAN_SELECT_LSB+:2];
      fan_rate_q[wd[`FAN_SELECT_LSB+:2] - 2'h1] <= wd[`FAN_RATE_BIT];
    end
  end

  assign fan_select      = fan_sel_q;
  assign fan_switch_rate = fan_rate_q;

  // mapping lives elsewhere; its rewrite resets input logic
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      in_reset_q <= 1'b0;
    end else begin
      in_reset_q <= is_write(`CMD_CHANNEL_CONFIG);
    end
  end

  assign input_logic_reset = in_reset_q;

  // read mux, unused bits stay zero
  always_comb begin
    rdata_d   = 128'h0;
    unknown_d = 1'b0;
    case (req.cmd)
      `CMD_BORDER_WIDTH:       rdata_d[4:0]   = border_q;
      `CMD_PATTERN_SIZE:       rdata_d[31:0]  = {pat_w_q, pat_h_q};
      `CMD_GAMMA_SHIFT:        rdata_d[23:0]  = gamma_q;
      `CMD_PIXEL_CLOCK_INFO:   rdata_d[47:0]  = pixclk_q;
      `CMD_SOURCE_DESCRIPTOR:  rdata_d        = src_desc_q;
      `CMD_PROGRAMMING_MODE:   rdata_d[0]     = prog_mode_active;
      `CMD_ARRAY_CLOCK_SPREAD: rdata_d[1:0]   = spread_q;
      `CMD_ARRAY_DIMENSIONS:   rdata_d[31:0]  = {arr_w_q, arr_h_q};
      `CMD_POWER_PHASE:        rdata_d[2:0]   = phase_q;
      `CMD_SOFT_RESTART:       rdata_d        = 128'h0;
      `CMD_RESTART_TALLY:      rdata_d[2:0]   = tally_q;
      `CMD_USB_CLOCK_GATE:     rdata_d[0]     = usb_q;
      `CMD_VERT_SMOOTHING:     rdata_d[4:0]   = vsmooth_q;
      `CMD_HORIZ_SMOOTHING:    rdata_d[4:0]   = hsmooth_q;
      `CMD_SCALER_SKIP:        rdata_d[0]     = skip_q;
      `CMD_FAN_DRIVE_SETUP: begin
        rdata_d[`FAN_SELECT_LSB+:2] = fan_sel_q;
        rdata_d[`FAN_RATE_BIT]      = fan_rate_q[fan_sel_q - 2'h1];
      end
      default:                 unknown_d      = 1'b1;
    endcase
  end

  // every request is answered one cycle later; reads return old contents, writes zero data
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsp_valid_q <= 1'b0;
      rsp_q       <= '0;
    end else begin
      rsp_valid_q <= req_valid;
      if (req_valid) begin
        rsp_q.rdata   <= req.write ? 128'h0 : rdata_d;
        rsp_q.unknown <= unknown_d &&
                         (req.cmd != `CMD_CHANNEL_CONFIG);
        rsp_q.status  <= '0;
        rsp_q.status[`STATUS_PROG_MODE_BIT] <= prog_mode_active;
        rsp_q.status[`STATUS_SHUTDOWN_BIT]  <= shutdown_q;
      end
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp       = rsp_q;

  assign pattern_width    = pat_w_q;
  assign pattern_height   = pat_h_q;
  assign gamma_shift      = gamma_q;
  assign line_pixel_total = pixclk_q[47:32];
  assign pixel_clock_hz   = pixclk_q[31:0];
  assign source_desc      = {src_desc_q[119], src_desc_q[112],
                             src_desc_q[111:16], src_desc_q[10:8],
                             src_desc_q[1:0]};

endmodule : display_control_cmd_regs

/* hw/display_control_pkg.sv */
// types carried between the register bank and its users
package display_control_pkg;

  typedef struct packed {
    logic         write;
    logic [7:0]   cmd;
    logic [127:0] wdata;
  } cmd_req_type;

  typedef struct packed {
    logic [15:0]  status;
    logic         unknown;
    logic [127:0] rdata;
  } cmd_rsp_type;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } gamma_shift_type;

  typedef struct packed {
    logic        source_live;
    logic        stereo_flag;
    logic [31:0] input_cadence;
    logic [15:0] input_rows;
    logic [15:0] input_columns;
    logic [15:0] native_rows;
    logic [15:0] native_columns;
    logic [2:0]  source_port;
    logic [1:0]  active_display;
  } source_desc_type;

  typedef enum {
    MODE_NORMAL,
    MODE_SHUTDOWN,
    MODE_PROGRAM
  } prog_mode_type;

  typedef enum logic [1:0] {
    RESTART_CPU_A  = 2'h0,
    RESTART_CPU_B  = 2'h1,
    RESTART_CPU_AB = 2'h2,
    RESTART_NONE   = 2'h3
  } restart_target_type;

endpackage : display_control_pkg

/* hw/display_control_regs.svh */
// command codes, field positions, limits and reset values of the block
`ifndef DISPLAY_CONTROL_REGS_SVH
`define DISPLAY_CONTROL_REGS_SVH

`define CMD_CHANNEL_CONFIG     8'h2A
`define CMD_BORDER_WIDTH       8'h2B
`define CMD_PATTERN_SIZE       8'h2C
`define CMD_GAMMA_SHIFT        8'h2D
`define CMD_PIXEL_CLOCK_INFO   8'h2E
`define CMD_SOURCE_DESCRIPTOR  8'h2F
`define CMD_PROGRAMMING_MODE   8'h30
`define CMD_ARRAY_CLOCK_SPREAD 8'h7F
`define CMD_ARRAY_DIMENSIONS   8'h81
`define CMD_POWER_PHASE        8'h84
`define CMD_SOFT_RESTART       8'h90
`define CMD_RESTART_TALLY      8'h91
`define CMD_USB_CLOCK_GATE     8'h93
`define CMD_VERT_SMOOTHING     8'h98
`define CMD_HORIZ_SMOOTHING    8'h99
`define CMD_SCALER_SKIP        8'h9A
`define CMD_FAN_DRIVE_SETUP    8'hA0

`define BORDER_MAX             5'h14
`define PATTERN_WIDTH_MIN      16'h0020
`define PATTERN_WIDTH_MAX      16'h04B0
`define PATTERN_HEIGHT_MIN     16'h0040
`define PATTERN_HEIGHT_MAX     16'h0780
`define SMOOTHING_FILTER_OFF   5'h10
`define RESTART_TALLY_MAX      3'h7
`define FAN_SELECT_RESET       2'h1
`define FAN_SELECT_LSB         16
`define FAN_RATE_BIT           8
`define SRC_DESC_MASK          128'h0081_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_0703
`define STATUS_PROG_MODE_BIT   0
`define STATUS_SHUTDOWN_BIT    1

`endif

/* sim/cmd_host.sv */
// host model issuing command reads and writes
`timescale 1ns/1ps
module cmd_host (
  input  wire logic                             clk,
  input  wire logic                             rsp_valid,
  input  wire display_control_pkg::cmd_rsp_type rsp,
  output logic                                  req_valid,
  output display_control_pkg::cmd_req_type      req
);
  display_control_pkg::cmd_rsp_type got;
  logic                             seen;
  initial begin
    req_valid = 1'b0;
    req       = '0;
  end
  // taken at the next rising edge, answer sampled half a cycle on
  task automatic xfer(input logic w, input logic [7:0] c,
                      input logic [127:0] d);
    @(negedge clk);
    req_valid = 1'b1;
    req       = '{write: w, cmd: c, wdata: d};
    @(negedge clk);
    seen      = rsp_valid;
    got       = rsp;
    req_valid = 1'b0;
    // released lines must not keep the last value
    req       = ~req;
  endtask : xfer
endmodule : cmd_host

/* sim/display_control_cmd_regs_asserts.sv */
// concurrent checks on the command register bank ports
`timescale 1ns/1ps
`include "display_control_regs.svh"
module display_control_cmd_regs_asserts (
  input wire logic                             clk,
  input wire logic                             rst_n,
  input wire logic                             req_valid,
  input wire display_control_pkg::cmd_req_type req,
  input wire logic                             rsp_valid,
  input wire logic                             test_pattern_gen_on,
  input wire logic                             line_pattern,
  input wire logic                             hi_res_source,
  input wire logic [4:0]                       border_width_out,
  input wire logic                             border_use_fg,
  input wire logic                             prog_mode_active,
  input wire logic                             partial_shutdown,
  input wire logic                             system_restart,
  input wire logic                             restart_cpu_a,
  input wire logic                             restart_cpu_b,
  input wire logic [4:0]                       vertical_smoothing,
  input wire logic                             vert_filter_on,
  input wire logic                             scaler_skip,
  input wire logic                             input_logic_reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic is_wr;
  assign is_wr = req_valid & req.write;

  property p_answer; req_valid |=> rsp_valid; endproperty
  a_answer: assert property (p_answer)
    else $error("request got no answer");
  property p_quiet; !req_valid |=> !rsp_valid; endproperty
  a_quiet: assert property (p_quiet)
    else $error("answer without request");
  property p_border_gate;
    (!test_pattern_gen_on || hi_res_source) |-> border_width_out == 5'h00;
  endproperty
  a_border_gate: assert property (p_border_gate)
    else $error("border shown while not allowed");
  property p_border_max; border_width_out <= `BORDER_MAX; endproperty
  a_border_max: assert property (p_border_max)
    else $error("border above limit");
  property p_border_colour; border_use_fg == line_pattern; endproperty
  a_border_colour: assert property (p_border_colour)
    else $error("border colour choice wrong");
  property p_filter_off;
    vert_filter_on == (vertical_smoothing != `SMOOTHING_FILTER_OFF);
  endproperty
  a_filter_off: assert property (p_filter_off)
    else $error("vertical filter enable wrong");
  property p_enter_prog;
    is_wr && req.cmd == `CMD_PROGRAMMING_MODE && req.wdata[0] &&
      !prog_mode_active && !partial_shutdown
      |=> partial_shutdown && !system_restart ##1 prog_mode_active;
  endproperty
  a_enter_prog: assert property (p_enter_prog)
    else $error("programming entry sequence wrong");
  property p_leave_prog;
    is_wr && req.cmd == `CMD_PROGRAMMING_MODE && req.wdata[0] &&
      prog_mode_active |=> system_restart && !prog_mode_active;
  endproperty
  a_leave_prog: assert property (p_leave_prog)
    else $error("programming exit sequence wrong");
  property p_both_cpus;
    is_wr && req.cmd == `CMD_SOFT_RESTART && req.wdata[1:0] == 2'h2
      |=> restart_cpu_a && restart_cpu_b;
  endproperty
  a_both_cpus: assert property (p_both_cpus)
    else $error("dual restart missing");
  property p_no_restart;
    is_wr && req.cmd == `CMD_SOFT_RESTART && req.wdata[1:0] == 2'h3
      |=> !restart_cpu_a && !restart_cpu_b;
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("restart on unused code");
  property p_cpu_a_only;
    is_wr && req.cmd == `CMD_SOFT_RESTART && req.wdata[1:0] == 2'h0
      |=> restart_cpu_a && !restart_cpu_b;
  endproperty
  a_cpu_a_only: assert property (p_cpu_a_only)
    else $error("first processor restart wrong");
  property p_cpu_b_only;
    is_wr && req.cmd == `CMD_SOFT_RESTART && req.wdata[1:0] == 2'h1
      |=> !restart_cpu_a && restart_cpu_b;
  endproperty
  a_cpu_b_only: assert property (p_cpu_b_only)
    else $error("second processor restart wrong");
  property p_map_reset;
    is_wr && req.cmd == `CMD_CHANNEL_CONFIG |=> input_logic_reset;
  endproperty
  a_map_reset: assert property (p_map_reset)
    else $error("input reset missing");
  property p_skip_hold;
    !(is_wr && req.cmd == `CMD_SCALER_SKIP) |=> $stable(scaler_skip);
  endproperty
  a_skip_hold: assert property (p_skip_hold)
    else $error("scaler skip changed unasked");
endmodule : display_control_cmd_regs_asserts

bind display_control_cmd_regs display_control_cmd_regs_asserts chk (
  .clk, .rst_n, .req_valid, .req, .rsp_valid, .test_pattern_gen_on,
  .line_pattern, .hi_res_source, .border_width_out, .border_use_fg,
  .prog_mode_active, .partial_shutdown, .system_restart,
  .restart_cpu_a, .restart_cpu_b, .vertical_smoothing,
  .vert_filter_on, .scaler_skip, .input_logic_reset);

/* sim/test_display_control_cmd_regs.sv */
// self-checking bench for the command register bank
`timescale 1ns/1ps
`include "display_control_regs.svh"
module test_display_control_cmd_regs;
  localparam logic [7:0] tcmd [8] = '{8'h2D, 8'h2E, 8'h2F, 8'h7F,
    8'h93, 8'h98, 8'h99, 8'h9A};
  localparam logic [127:0] tmsk [8] = '{128'hFF_FFFF,
    128'hFFFF_FFFF_FFFF, 128'h0081_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_0703,
    128'h3, 128'h1, 128'h1F, 128'h1F, 128'h1};
  logic                             clk;
  logic                             rst_n;
  logic                             req_valid;
  display_control_pkg::cmd_req_type req;
  logic                             rsp_valid;
  display_control_pkg::cmd_rsp_type rsp;
  logic                             test_pattern_gen_on;
  logic                             line_pattern;
  logic                             hi_res_source;
  logic [15:0]                      array_width_in;
  logic [15:0]                      array_height_in;
  logic [2:0]                       power_phase_in;
  logic [4:0]                       border_width_out;
  logic                             border_use_fg;
  logic [15:0]                      line_pixel_total;
  display_control_pkg::source_desc_type source_desc;
  logic [15:0]                      pattern_width;
  logic [1:0]                       spread_level;
  logic                             vert_filter_on;
  logic                             horiz_filter_on;
  logic [2:0]                       fan_switch_rate;
  logic [127:0]                     d;
  int                               err_count;
  int                               checked;

  display_control_cmd_regs DUT (
    .clk, .rst_n, .req_valid, .req, .rsp_valid, .rsp, .test_pattern_gen_on,
    .line_pattern, .hi_res_source, .array_width_in, .array_height_in,
    .power_phase_in, .border_width_out, .border_use_fg,
    .pattern_width, .pattern_height(), .gamma_shift(),
    .line_pixel_total, .pixel_clock_hz(), .source_desc,
    .prog_mode_active(), .partial_shutdown(), .system_restart(),
    .spread_level, .restart_cpu_a(), .restart_cpu_b(),
    .usb_clock_on(), .vertical_smoothing(), .horizontal_smoothing(),
    .vert_filter_on, .horiz_filter_on, .scaler_skip(),
    .fan_select(), .fan_switch_rate, .input_logic_reset());
  cmd_host host (.clk, .rsp_valid, .rsp, .req_valid, .req);

  initial clk = 1'b0;
  always #50 clk = ~clk;

  task automatic chk_data(input logic [127:0] g, input logic [127:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t read %h expected %h", $time, g, e);
    end
  endtask : chk_data
  task automatic chk_field(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t field %h expected %h", $time, g, e);
    end
  endtask : chk_field
  task automatic wr(input logic [7:0] c, input logic [127:0] v);
    host.xfer(1'b1, c, v);
    chk_field(16'(host.seen), 16'h0001);
  endtask : wr
  task automatic rd(input logic [7:0] c, input logic [127:0] e);
    host.xfer(1'b0, c, 128'h0);
    chk_data(host.got.rdata, e);
  endtask : rd
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask : done
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // tests take under two hundred cycles; this is far beyond
  initial begin
    #400000;
    err_count++;
    $display("[FAIL] %0t watchdog ran out", $time);
    conclude();
  end

  initial begin
    err_count = 0;
    checked = 0;
    rst_n = 1'b0;
    test_pattern_gen_on = 1'b0;
    line_pattern = 1'b0;
    hi_res_source = 1'b0;
    array_width_in = 16'h04B0;
    array_height_in = 16'h0780;
    power_phase_in = 3'h5;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    rd(`CMD_FAN_DRIVE_SETUP, 128'h1_0000);
    rd(`CMD_BORDER_WIDTH, 128'h0);
    chk_field(16'({vert_filter_on, horiz_filter_on}), 16'h0003);
    rd(`CMD_ARRAY_DIMENSIONS, 128'h04B0_0780);
    wr(`CMD_ARRAY_DIMENSIONS, 128'h1234_5678);
    rd(`CMD_ARRAY_DIMENSIONS, 128'h04B0_0780);
    wr(`CMD_POWER_PHASE, 128'h2);
    rd(`CMD_POWER_PHASE, 128'h5);
    done("reset_and_read_only");
    wr(`CMD_PATTERN_SIZE, 128'h04B0_0040);
    rd(`CMD_PATTERN_SIZE, 128'h04B0_0040);
    chk_field(pattern_width, 16'h04B0);
    wr(`CMD_PATTERN_SIZE, 128'h001F_0100);
    wr(`CMD_PATTERN_SIZE, 128'h0020_0781);
    rd(`CMD_PATTERN_SIZE, 128'h04B0_0040);
    wr(`CMD_PATTERN_SIZE, 128'h0020_0780);
    rd(`CMD_PATTERN_SIZE, 128'h0020_0780);
    // a smaller mirror array caps an otherwise legal width
    array_width_in = 16'h0100;
    wr(`CMD_PATTERN_SIZE, 128'h0200_0100);
    rd(`CMD_PATTERN_SIZE, 128'h0020_0780);
    array_width_in = 16'h04B0;
    done("pattern_size");
    // border reaches the output only once the generator runs
    test_pattern_gen_on = 1'b1;
    wr(`CMD_BORDER_WIDTH, 128'hF4);
    rd(`CMD_BORDER_WIDTH, 128'h14);
    chk_field(16'(border_width_out), 16'h0014);
    wr(`CMD_BORDER_WIDTH, 128'h15);
    rd(`CMD_BORDER_WIDTH, 128'h14);
    chk_field(16'(border_use_fg), 16'h0000);
    hi_res_source = 1'b1;
    line_pattern = 1'b1;
    @(negedge clk);
    chk_field(16'(border_width_out), 16'h0000);
    chk_field(16'(border_use_fg), 16'h0001);
    hi_res_source = 1'b0;
    done("border");
    for (int p = 0; p < 2; p++) begin
      d = p ? 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210 : '1;
      for (int i = 0; i < 8; i++) begin
        wr(tcmd[i], d);
        rd(tcmd[i], d & tmsk[i]);
      end
    end
    // fields of the last descriptor and pixel word written
    d = 128'({1'b0, 1'b1, 32'h4567_89AB, 16'hCDEF, 16'hFEDC,
              16'hBA98, 16'h7654, 3'h2, 2'h0});
    chk_data(128'(source_desc), d);
    chk_field(line_pixel_total, 16'hBA98);
    for (int i = 0; i < 4; i++) begin
      wr(`CMD_ARRAY_CLOCK_SPREAD, 128'(i));
      chk_field(16'(spread_level), 16'(i));
    end
    // graphics sources want both filters off
    wr(`CMD_VERT_SMOOTHING, 128'h10);
    wr(`CMD_HORIZ_SMOOTHING, 128'h10);
    chk_field(16'({vert_filter_on, horiz_filter_on}), 16'h0000);
    wr(`CMD_SCALER_SKIP, 128'h0);
    done("field_layout");
    wr(`CMD_FAN_DRIVE_SETUP, 128'h0_0100);
    rd(`CMD_FAN_DRIVE_SETUP, 128'h1_0000);
    wr(`CMD_FAN_DRIVE_SETUP, 128'h3_0100);
    rd(`CMD_FAN_DRIVE_SETUP, 128'h3_0100);
    wr(`CMD_FAN_DRIVE_SETUP, 128'h1_0000);
    rd(`CMD_FAN_DRIVE_SETUP, 128'h1_0000);
    chk_field(16'(fan_switch_rate), 16'h0004);
    done("fan");
    wr(`CMD_PROGRAMMING_MODE, 128'h0);
    rd(`CMD_PROGRAMMING_MODE, 128'h0);
    wr(`CMD_PROGRAMMING_MODE, 128'h1);
    rd(`CMD_PROGRAMMING_MODE, 128'h1);
    chk_field(host.got.status, 16'h0001);
    wr(`CMD_PROGRAMMING_MODE, 128'h1);
    rd(`CMD_PROGRAMMING_MODE, 128'h0);
    rd(`CMD_RESTART_TALLY, 128'h1);
    wr(`CMD_SOFT_RESTART, 128'h3);
    rd(`CMD_RESTART_TALLY, 128'h1);
    for (int i = 0; i < 7; i++) begin
      wr(`CMD_SOFT_RESTART, 128'(i % 3));
    end
    rd(`CMD_RESTART_TALLY, 128'h7);
    // mapping rewrite after a clock source change
    wr(`CMD_CHANNEL_CONFIG, 128'h0);
    host.xfer(1'b0, 8'h55, 128'h0);
    chk_field(16'(host.got.unknown), 16'h0001);
    done("modes_and_restart");
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd(`CMD_FAN_DRIVE_SETUP, 128'h1_0000);
    rd(`CMD_RESTART_TALLY, 128'h0);
    done("second_reset");
    conclude();
  end
endmodule : test_display_control_cmd_regs
